// >>> bcel_pkg.sv
package bcel_pkg;

	localparam int unsigned CHAN_COUNT = 4;
	localparam int unsigned ADDR_W     = 4;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned Q_DEPTH    = 4;
	localparam int unsigned PTR_W      = 2;
	localparam int unsigned WORD_W     = 16;

	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CHAN_ENABLE = 4'h0;
	localparam logic [3:0] ADDR_LOOP_SELECT = 4'h1;
	localparam logic [3:0] ADDR_BUSY_STATUS = 4'h2;
	localparam logic [3:0] ADDR_TX_DATA_LO  = 4'h4;
	localparam logic [3:0] ADDR_TX_DATA_HI  = 4'h5;
	localparam logic [3:0] ADDR_RX_DATA_LO  = 4'h6;
	localparam logic [3:0] ADDR_RX_DATA_HI  = 4'h7;
	localparam logic [3:0] ADDR_CHAN_SELECT = 4'h8;
	localparam logic [3:0] ADDR_PTR_STATUS  = 4'h9;

	localparam logic [7:0] RESET_ENABLE = 8'h00;
	localparam logic [7:0] RESET_LOOP   = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;
	localparam logic [15:0] WORD_ZERO   = 16'h0000;

	// Cycles a word takes on the wire; arbitrary transfer length.
	localparam logic [3:0] XFER_CYCLES = 4'h8;

	typedef enum logic [2:0] {
		CH_OFF  = 3'b001,
		CH_BUS  = 3'b010,
		CH_LOOP = 3'b100
	} bcel_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bcel_req_t;

	typedef struct packed {
		logic clr;
		logic push;
		logic pop;
		logic [WORD_W-1:0] wdata;
	} bcel_qcmd_t;

endpackage

// >>> bcel_queue.sv
module bcel_queue
	import bcel_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire bcel_qcmd_t        cmd_i,
	output logic [WORD_W-1:0]      head_o,
	output logic [PTR_W-1:0]       wptr_o,
	output logic [PTR_W-1:0]       rptr_o,
	output logic                   empty_o
);

	logic [WORD_W-1:0] mem [Q_DEPTH];
	logic [WORD_W-1:0] next_mem [Q_DEPTH];
	logic [PTR_W-1:0]  wptr;
	logic [PTR_W-1:0]  rptr;
	logic [PTR_W:0]    fill;
	logic [PTR_W-1:0]  next_wptr;
	logic [PTR_W-1:0]  next_rptr;
	logic [PTR_W:0]    next_fill;
	logic              do_push;
	logic              do_pop;

	// Pointers wrap naturally at the queue depth in every mode.
	always_comb begin
		do_push   = cmd_i.push && (fill != (PTR_W+1)'(Q_DEPTH));
		do_pop    = cmd_i.pop && (fill != '0);
		next_mem  = mem;
		next_wptr = wptr;
		next_rptr = rptr;
		next_fill = fill;
		if (cmd_i.clr) begin
			next_wptr = '0;
			next_rptr = '0;
			next_fill = '0;
			for (int i = 0; i < Q_DEPTH; i++) begin
				next_mem[i] = WORD_ZERO;
			end
		end else begin
			if (do_push) begin
				next_mem[wptr] = cmd_i.wdata;
				next_wptr = wptr + 1'b1;
			end
			if (do_pop) begin
				next_rptr = rptr + 1'b1;
			end
			next_fill = fill + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr <= '0;
			rptr <= '0;
			fill <= '0;
			for (int i = 0; i < Q_DEPTH; i++) begin
				mem[i] <= WORD_ZERO;
			end
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			fill <= next_fill;
			mem  <= next_mem;
		end
	end

	assign head_o  = mem[rptr];
	assign wptr_o  = wptr;
	assign rptr_o  = rptr;
	assign empty_o = (fill == '0);

endmodule

// >>> bcel_top.sv
module bcel_top
	import bcel_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic [ADDR_W-1:0]      addr_i,
	input  wire logic [DATA_W-1:0]      wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic [DATA_W-1:0]           rdata_o,
	input  wire logic [CHAN_COUNT-1:0]  bus_rx_i,
	output logic [CHAN_COUNT-1:0]       bus_tx_o,
	output logic [CHAN_COUNT-1:0]       bus_tx_oe_o
);

	////////////////////////////////////////////////////////////////////
	bcel_req_t req;
	logic [CHAN_COUNT-1:0] rx_meta;
	logic [CHAN_COUNT-1:0] rx_sync;
	logic [CHAN_COUNT-1:0] on_bit;
	logic [CHAN_COUNT-1:0] loop_bit;
	logic [CHAN_COUNT-1:0] next_on_bit;
	logic [CHAN_COUNT-1:0] next_loop_bit;
	logic [1:0]            sel;
	logic [1:0]            next_sel;
	logic [DATA_W-1:0]     rdata;
	logic [DATA_W-1:0]     next_rdata;
	logic [WORD_W-1:0]     tx_hold;
	logic [WORD_W-1:0]     next_tx_hold;
	logic [CHAN_COUNT-1:0] chan_clr;
	logic [CHAN_COUNT-1:0] busy;
	logic [CHAN_COUNT-1:0] tx_q_empty;
	logic [CHAN_COUNT-1:0] rx_q_empty;
	logic [WORD_W-1:0]     rx_head [CHAN_COUNT];
	logic [PTR_W-1:0]      tx_wp [CHAN_COUNT];
	logic [PTR_W-1:0]      tx_rp [CHAN_COUNT];
	logic [PTR_W-1:0]      rx_wp [CHAN_COUNT];
	logic [PTR_W-1:0]      rx_rp [CHAN_COUNT];

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta <= '0;
			rx_sync <= '0;
		end else begin
			rx_meta <= bus_rx_i;
			rx_sync <= rx_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control registers take effect on the edge that ends the write.
	always_comb begin
		next_on_bit   = on_bit;
		next_loop_bit = loop_bit;
		next_sel      = sel;
		next_tx_hold  = tx_hold;
		if (req.wr) begin
			unique case (req.addr)
				ADDR_CHAN_ENABLE: begin
					next_on_bit = req.wdata[CHAN_COUNT-1:0];
				end
				ADDR_LOOP_SELECT: begin
					next_loop_bit = req.wdata[CHAN_COUNT-1:0];
				end
				ADDR_CHAN_SELECT: next_sel = req.wdata[1:0];
				ADDR_TX_DATA_LO:  next_tx_hold[7:0] = req.wdata;
				ADDR_TX_DATA_HI:  next_tx_hold[15:8] = req.wdata;
				default: ;
			endcase
		end
		// Loop wins over enable, so a channel is never on both paths.
		next_on_bit = next_on_bit & ~next_loop_bit;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_bit   <= RESET_ENABLE[CHAN_COUNT-1:0];
			loop_bit <= RESET_LOOP[CHAN_COUNT-1:0];
			sel      <= '0;
			tx_hold  <= WORD_ZERO;
		end else begin
			on_bit   <= next_on_bit;
			loop_bit <= next_loop_bit;
			sel      <= next_sel;
			tx_hold  <= next_tx_hold;
		end
	end

	always_comb begin
		next_rdata = READ_ZERO;
		if (req.rd) begin
			unique case (req.addr)
				ADDR_CHAN_ENABLE: next_rdata = DATA_W'(on_bit);
				ADDR_LOOP_SELECT: next_rdata = DATA_W'(loop_bit);
				ADDR_BUSY_STATUS: next_rdata = DATA_W'(busy);
				ADDR_CHAN_SELECT: next_rdata = DATA_W'(sel);
				ADDR_RX_DATA_LO:  next_rdata = rx_head[sel][7:0];
				ADDR_RX_DATA_HI:  next_rdata = rx_head[sel][15:8];
				ADDR_PTR_STATUS:  next_rdata = {tx_wp[sel], tx_rp[sel],
					rx_wp[sel], rx_rp[sel]};
				default:          next_rdata = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata <= READ_ZERO;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign rdata_o = rdata;

	////////////////////////////////////////////////////////////////////
	// Per channel: mode machine, transfer engine and two queues.
	for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_chan
		bcel_mode_t mode;
		bcel_mode_t next_mode;
		logic [3:0] cnt;
		logic [3:0] next_cnt;
		logic [WORD_W-1:0] shift;
		logic [WORD_W-1:0] next_shift;
		logic [WORD_W-1:0] tx_head;
		logic tx_o;
		logic oe_o;
		logic next_tx;
		logic next_oe;
		logic rx_full;
		bcel_qcmd_t tx_cmd;
		bcel_qcmd_t rx_cmd;

		always_comb begin
			next_mode = CH_OFF;
			if (loop_bit[c]) begin
				next_mode = CH_LOOP;
			end else if (on_bit[c]) begin
				next_mode = CH_BUS;
			end
		end

		// Any mode change clears the channel: covers disable, loop entry
		// and loop exit alike.
		assign chan_clr[c] = (next_mode != mode);

		always_comb begin
			next_cnt   = cnt;
			next_shift = shift;
			tx_cmd     = '{clr: chan_clr[c], push: 1'b0, pop: 1'b0,
				wdata: tx_hold};
			rx_cmd     = '{clr: chan_clr[c], push: 1'b0, pop: 1'b0,
				wdata: shift};
			if (req.wr && req.addr == ADDR_TX_DATA_HI && sel == 2'(c)) begin
				tx_cmd.push = 1'b1;
				tx_cmd.wdata = {req.wdata, tx_hold[7:0]};
			end
			if (req.rd && req.addr == ADDR_RX_DATA_HI && sel == 2'(c)) begin
				rx_cmd.pop = 1'b1;
			end
			if (chan_clr[c] || mode == CH_OFF) begin
				next_cnt   = '0;
				next_shift = WORD_ZERO;
			end else if (cnt == '0) begin
				if (!tx_q_empty[c]) begin
					tx_cmd.pop = 1'b1;
					next_shift = tx_head;
					next_cnt   = XFER_CYCLES;
				end
			end else begin
				// Loop feeds the shifter its own output, bus its receiver.
				next_shift = {shift[WORD_W-2:0], (mode == CH_LOOP) ?
					shift[WORD_W-1] : rx_sync[c]};
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					rx_cmd.push  = 1'b1;
					rx_cmd.wdata = next_shift;
				end
			end
			next_oe = (mode == CH_BUS) && !chan_clr[c] && (next_cnt != '0);
			next_tx = next_oe & next_shift[WORD_W-1];
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mode  <= CH_OFF;
				cnt   <= '0;
				shift <= WORD_ZERO;
				tx_o  <= 1'b0;
				oe_o  <= 1'b0;
			end else begin
				mode  <= next_mode;
				cnt   <= next_cnt;
				shift <= next_shift;
				tx_o  <= next_tx;
				oe_o  <= next_oe;
			end
		end

		assign busy[c]        = (cnt != '0);
		assign rx_full        = (rx_wp[c] == rx_rp[c]) && !rx_q_empty[c];
		assign bus_tx_o[c]    = tx_o;
		assign bus_tx_oe_o[c] = oe_o;

		bcel_queue u_tx_q (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.cmd_i   (tx_cmd),
			.head_o  (tx_head),
			.wptr_o  (tx_wp[c]),
			.rptr_o  (tx_rp[c]),
			.empty_o (tx_q_empty[c])
		);

		bcel_queue u_rx_q (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.cmd_i   (rx_cmd),
			.head_o  (rx_head[c]),
			.wptr_o  (rx_wp[c]),
			.rptr_o  (rx_rp[c]),
			.empty_o (rx_q_empty[c])
		);

		a_off_tristate: assert property (@(posedge clk_i)
			disable iff (rst_i) (mode != CH_BUS) |-> !oe_o)
			else $error("driver enabled while channel not on bus");
		a_disable_halts: assert property (@(posedge clk_i)
			disable iff (rst_i) $fell(on_bit[c]) && !loop_bit[c]
			|=> cnt == '0 && !oe_o)
			else $error("transfer not halted after disable");
		// The last bus bit may still stand in the cycle the loop bit rises,
		// so the check waits until the mode itself has switched.
		a_loop_no_bus: assert property (@(posedge clk_i)
			disable iff (rst_i) mode == CH_LOOP && loop_bit[c]
			|-> !on_bit[c] && !oe_o && !tx_o)
			else $error("loopback data reached the bus");
		// A full receive queue drops the word, so that case is left out.
		a_loop_pass: assert property (@(posedge clk_i)
			disable iff (rst_i) mode == CH_LOOP && cnt == 4'h1
			&& !chan_clr[c] && !rx_full
			|=> rx_wp[c] == $past(rx_wp[c]) + 2'd1)
			else $error("loop word not stored in receive queue");
	end

	////////////////////////////////////////////////////////////////////
	sequence s_en_write;
		wr_i && addr_i == ADDR_CHAN_ENABLE && !loop_bit[0];
	endsequence

	a_write_applies: assert property (@(posedge clk_i)
		disable iff (rst_i) s_en_write
		|=> on_bit[0] == $past(wdata_i[0]))
		else $error("enable write not applied next cycle");
	a_clr_ptrs: assert property (@(posedge clk_i)
		disable iff (rst_i) chan_clr[0]
		|=> tx_wp[0] == '0 && rx_wp[0] == '0)
		else $error("queues not reset on mode change");
	a_loop_clears_en: assert property (@(posedge clk_i)
		disable iff (rst_i) $rose(loop_bit[0]) |-> !on_bit[0])
		else $error("enable left set on loop entry");
	a_reset_off: assert property (@(posedge clk_i)
		$past(rst_i) |-> on_bit == '0 && bus_tx_oe_o == '0)
		else $error("channel enabled after reset");

endmodule

// >>> bcel_node.sv
module bcel_node
	import bcel_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic [CHAN_COUNT-1:0] tx_i,
	input  wire logic [CHAN_COUNT-1:0] oe_i,
	output logic      [CHAN_COUNT-1:0] rx_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial rx_o = '0;

	// A driven line is echoed back by the node. A released line has no
	// pull, so it toggles every cycle rather than keeping its last level.
	always @(posedge clk_i) begin
		for (int c = 0; c < CHAN_COUNT; c++) begin
			rx_o[c] <= oe_i[c] ? tx_i[c] : ~rx_o[c];
		end
	end
endmodule

// >>> tb_bcel_top.sv
module tb_bcel_top
	import bcel_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  clk_i;
	logic                  rst_i;
	logic [ADDR_W-1:0]     addr_i;
	logic [DATA_W-1:0]     wdata_i;
	logic                  wr_i;
	logic                  rd_i;
	logic [DATA_W-1:0]     rdata_o;
	logic [CHAN_COUNT-1:0] bus_rx_i;
	logic [CHAN_COUNT-1:0] bus_tx_o;
	logic [CHAN_COUNT-1:0] bus_tx_oe_o;
	int                    n_errors;
	int                    checks;
	logic                  watch;
	logic [7:0]            leak;
	logic [15:0]           word;
	logic [3:0]            bits;

	bcel_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o),
		.bus_tx_oe_o(bus_tx_oe_o));

	bcel_node i_node (.clk_i(clk_i), .tx_i(bus_tx_o),
		.oe_i(bus_tx_oe_o), .rx_o(bus_rx_i));

	always #4 clk_i = ~clk_i;

	// Any drive on channel 1 while it loops back counts as a leak.
	always @(posedge clk_i) begin
		if (watch && (bus_tx_oe_o[1] !== 1'b0 || bus_tx_o[1] !== 1'b0)) begin
			leak <= leak + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic chk_rd(input string name, input logic [3:0] a,
		input logic [7:0] exp);
		logic [7:0] v;
		reg_rd(a, v);
		chk(name, {8'h00, exp}, {8'h00, v});
	endtask

	task automatic push(input logic [15:0] w);
		reg_wr(ADDR_TX_DATA_LO, w[7:0]);
		reg_wr(ADDR_TX_DATA_HI, w[15:8]);
	endtask

	task automatic pop(output logic [15:0] w);
		reg_rd(ADDR_RX_DATA_LO, w[7:0]);
		reg_rd(ADDR_RX_DATA_HI, w[15:8]);
	endtask

	// Transfers finish on their own schedule, so poll with a bound.
	task automatic wait_ptr(input logic [7:0] exp);
		logic [7:0] v;
		int n;
		v = ~exp;
		n = 0;
		while (v !== exp && n < 200) begin
			reg_rd(ADDR_PTR_STATUS, v);
			n++;
		end
		chk("pointers", {8'h00, exp}, {8'h00, v});
		if (v !== exp) close_out();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		clk_i = 1'b0;
		rst_i = 1'b1;
		addr_i = '0;
		wdata_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		n_errors = 0;
		checks = 0;
		watch = 1'b0;
		leak = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_rd("enable", ADDR_CHAN_ENABLE, RESET_ENABLE);
		chk_rd("loop", ADDR_LOOP_SELECT, RESET_LOOP);
		chk("oe", 16'h0000, {12'h000, bus_tx_oe_o});
		chk_rd("unmapped", 4'h3, READ_ZERO);
		reg_wr(ADDR_CHAN_ENABLE, 8'h01);
		chk_rd("enable", ADDR_CHAN_ENABLE, 8'h01);
		push(16'hA5A5);
		wait_ptr(8'h54);
		pop(word);
		wait_ptr(8'h55);
		// A word is caught on the wire, then the channel is switched off.
		push(16'h3C3C);
		n = 0;
		@(posedge clk_i);
		#1;
		while (bus_tx_oe_o[0] !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("oe on", 16'h0001, {15'h0000, bus_tx_oe_o[0]});
		// The top four bits of the word leave first, MSB first.
		for (int i = 3; i >= 0; i--) begin
			bits[i] = bus_tx_o[0];
			@(posedge clk_i);
			#1;
		end
		chk("wire bits", 16'h0003, {12'h000, bits});
		reg_wr(ADDR_CHAN_ENABLE, 8'h00);
		// One edge on, an unhalted transfer would still drive the line.
		@(posedge clk_i);
		#1;
		chk("oe off", 16'h0000, {12'h000, bus_tx_oe_o});
		chk_rd("pointers", ADDR_PTR_STATUS, 8'h00);
		chk_rd("busy", ADDR_BUSY_STATUS, 8'h00);
		////////////////////////////////////////////////////////////////
		reg_wr(ADDR_CHAN_ENABLE, 8'h02);
		reg_wr(ADDR_LOOP_SELECT, 8'h02);
		chk_rd("enable", ADDR_CHAN_ENABLE, 8'h00);
		reg_wr(ADDR_CHAN_SELECT, 8'h01);
		chk_rd("select", ADDR_CHAN_SELECT, 8'h01);
		chk_rd("pointers", ADDR_PTR_STATUS, 8'h00);
		watch = 1'b1;
		push(16'hA5A5);
		push(16'h5A5A);
		wait_ptr(8'hA8);
		pop(word);
		chk("rx word", 16'hA5A5, word);
		pop(word);
		chk("rx word", 16'h5A5A, word);
		push(16'hC3C3);
		push(16'h9696);
		push(16'h0F0F);
		wait_ptr(8'h56);
		watch = 1'b0;
		chk("loop bus", 16'h0000, {8'h00, leak});
		reg_wr(ADDR_LOOP_SELECT, 8'h00);
		chk_rd("pointers", ADDR_PTR_STATUS, 8'h00);
		chk_rd("enable", ADDR_CHAN_ENABLE, RESET_ENABLE);
		chk_rd("loop", ADDR_LOOP_SELECT, RESET_LOOP);
		chk_rd("busy", ADDR_BUSY_STATUS, 8'h00);
		// A reset in mid-transfer must switch every channel off.
		reg_wr(ADDR_CHAN_ENABLE, 8'h0F);
		push(16'h1234);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_rd("enable", ADDR_CHAN_ENABLE, RESET_ENABLE);
		chk("oe", 16'h0000, {12'h000, bus_tx_oe_o});
		close_out();
	end
endmodule
